// *** src/rx_pkg.sv ***
/*
 Constants, state types and the notes for the serial receive status block.
 Assumes a 250 MHz system clock and a one-cycle oversample tick from outside.
*/
// Functional notes
// - Missing logic 1 at the stop-bit position sets the framing fault flag.
// - A break character, having no stop bit, also sets the framing fault flag.
// - Framing fault rises in the same cycle as receive-full for that character.
// - One stop sample wrong gives noise only; two or more give framing fault.
// - Every valid falling edge inside a character realigns the oversample phase.
// - Stop sampling ends at 154 oversample ticks (8-bit) or 170 ticks (9-bit), 16 per bit.
// - Receiver standby suppresses every receiver interrupt request.
// - Address-mark wakeup: MSB set clears standby and sets receive-full.
// - Idle wakeup clears standby without setting line-quiet or receive-full.
// - Quiet count start select chooses counting after start bit or stop bit.
// - Receive-full sets on buffer transfer and requests interrupt when enabled.
// - Line-quiet sets after 10 or 11 ones and requests interrupt when enabled.
// - Overrun keeps the old buffer, drops the new character; enable gates interrupt.
// - Noise in start, data or stop bits sets noise flag; enable gates interrupt.
// - Framing fault requests an error interrupt when its enable is set.
// - Parity mismatch sets parity fault; enable gates error interrupt.
// - In stop state the block halts, keeps registers, drops the partial character.
// - With debug clear allowed, clears during break act and stay cleared.
// - With debug clear barred, break accesses leave flags; armed clear completes after.
// - The line is sampled by an oversample clock at sixteen times the baud rate.
// - Start bit verified at phases 3, 5, 7, accepted when at most one is 1.
// - Data bits take a majority of phases 8, 9, 10; disagreement flags noise.
// - A character-length control selects 8-bit or 9-bit characters.
package rx_pkg;
   localparam int unsigned CLK_MHZ = 250;
   localparam logic [3:0] PH_START_A = 4'h3;
   localparam logic [3:0] PH_START_B = 4'h5;
   localparam logic [3:0] PH_START_C = 4'h7;
   localparam logic [3:0] PH_BIT_A = 4'h8;
   localparam logic [3:0] PH_BIT_B = 4'h9;
   localparam logic [3:0] PH_BIT_C = 4'ha;
   localparam logic [3:0] PH_LAST = 4'hf;
   localparam logic [7:0] STOP_TICKS_8 = 8'h9a;
   localparam logic [7:0] STOP_TICKS_9 = 8'haa;
   localparam logic [3:0] STOP_INDEX_8 = 4'h9;
   localparam logic [3:0] STOP_INDEX_9 = 4'ha;
   localparam logic [3:0] QUIET_ONES_8 = 4'ha;
   localparam logic [3:0] QUIET_ONES_9 = 4'hb;
   localparam logic [8:0] DATA_RESET = 9'h000;
   localparam logic [7:0] FLAGS_RESET = 8'h00;
   typedef enum logic [1:0] {idle_st, start_st, data_st} rx_state_type;
endpackage : rx_pkg

// *** src/sample_if.sv ***
/*
 Carries per-tick sample votes from the voter to the receive core.
 Assumes both ends run on clk_sys.
*/
`timescale 1ns/1ps
interface sample_if;
   logic tick;
   logic [3:0] phase;
   logic line;
   logic vote;
   logic noisy;
   logic [2:0] ones;
   modport voter (input tick, input phase, input line, output vote, output noisy, output ones);
   modport core (output tick, output phase, output line, input vote, input noisy, input ones);
endinterface : sample_if

// *** src/sample_voter.sv ***
/*
 Collects three samples at the data phases and forms vote, noise and count.
 Assumes the core resets phase per bit and ticks once per oversample cycle.
*/
`timescale 1ns/1ps
module sample_voter
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic ce,
   sample_if.voter sif
);
   typedef struct packed
   {
      logic [2:0] smp;
   } voter_state_type;
   voter_state_type s_q;
   voter_state_type s_d;
   logic [2:0] cur;
   // Samples fold in at phases 8, 9 and 10 and are voted on the last one.
   always_comb
   begin
      s_d = s_q;
      cur = s_q.smp;
      if (sif.tick && sif.phase == rx_pkg::PH_BIT_A)
      begin
         s_d.smp = {2'b00, sif.line};
      end
      else if (sif.tick && (sif.phase == rx_pkg::PH_BIT_B || sif.phase == rx_pkg::PH_BIT_C))
      begin
         s_d.smp = {s_q.smp[1:0], sif.line};
      end
      if (sif.phase == rx_pkg::PH_BIT_C)
      begin
         cur = {s_q.smp[1:0], sif.line};
      end
   end
   // Majority and disagreement are combinational so the core sees them on the tick.
   assign sif.ones = 3'(cur[0]) + 3'(cur[1]) + 3'(cur[2]);
   assign sif.vote = (sif.ones >= 3'h2);
   assign sif.noisy = (sif.ones != 3'h0) && (sif.ones != 3'h3);
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         s_q <= '0;
      end
      else if (ce)
      begin
         s_q <= s_d;
      end
   end
endmodule : sample_voter

// *** src/pin_sync.sv ***
/*
 Two-flop synchroniser for the asynchronous receive pin.
 Assumes the pin idles high; reset loads ones so no false start appears.
*/
`timescale 1ns/1ps
module pin_sync
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic ce,
   input wire logic pin,
   output logic synced
);
   typedef struct packed
   {
      logic meta;
      logic sync;
   } sync_state_type;
   sync_state_type s_q;
   sync_state_type s_d;
   // Only the second flop is visible outside.
   always_comb
   begin
      s_d = s_q;
      s_d.meta = pin;
      s_d.sync = s_q.meta;
   end
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         s_q <= '1;
      end
      else if (ce)
      begin
         s_q <= s_d;
      end
   end
   assign synced = s_q.sync;
endmodule : pin_sync

// *** src/rx_status.sv ***
/*
 Receive status and control core: start search, resync, stop check, standby,
 flags, interrupts, two-step clear and debug-break protection.
 Assumes an oversample tick at sixteen times the baud rate from a baud generator,
 and CPU strobes that are one-cycle pulses synchronous to clk_sys.
*/
`timescale 1ns/1ps
module rx_status
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic ce,
   input wire logic rx_pin,
   input wire logic oversample_clock,
   input wire logic char_9bit,
   input wire logic parity_enable,
   input wire logic parity_odd,
   input wire logic address_wake,
   input wire logic quiet_count_start_select,
   input wire logic standby_set,
   input wire logic rx_full_irq_enable,
   input wire logic quiet_irq_enable,
   input wire logic overrun_irq_enable,
   input wire logic noise_irq_enable,
   input wire logic framing_irq_enable,
   input wire logic parity_irq_enable,
   input wire logic stop_mode,
   input wire logic debug_break,
   input wire logic debug_clear_allow,
   input wire logic status_read,
   input wire logic data_access,
   output logic [8:0] rx_data_buffer,
   output logic receiver_standby,
   output logic rx_full_flag,
   output logic quiet_flag,
   output logic overrun_flag,
   output logic noise_flag,
   output logic framing_fault_flag,
   output logic parity_fault_flag,
   output logic rx_irq,
   output logic err_irq
);
   typedef struct packed
   {
      rx_pkg::rx_state_type st;
      logic [3:0] phase;
      logic [3:0] bit_idx;
      logic [7:0] ticks;
      logic [2:0] hist;
      logic [2:0] start_smp;
      logic [8:0] shift;
      logic prev_bit;
      logic char_noise;
      logic [3:0] ones;
      logic quiet_armed;
      logic [8:0] buf_q;
      logic standby;
      logic full;
      logic quiet;
      logic ovr;
      logic nf;
      logic fe;
      logic pf;
      logic armed;
      logic rx_irq;
      logic err_irq;
   } core_state_type;
   core_state_type s_q;
   core_state_type s_d;
   logic line;
   logic run;
   logic tick;
   logic [3:0] stop_idx;
   logic [3:0] quiet_len;
   logic [8:0] data_word;
   logic par_bad;
   logic clear_ok;
   logic [2:0] st_ones;
   sample_if sif ();
   pin_sync u_sync
   (
      .clk_sys(clk_sys),
      .rst(rst),
      .ce(ce),
      .pin(rx_pin),
      .synced(line)
   );
   sample_voter u_vote
   (
      .clk_sys(clk_sys),
      .rst(rst),
      .ce(run),
      .sif(sif)
   );
   // Stop mode freezes the core and voter but not the pin synchroniser; frame state goes idle, other registers hold.
   assign run = ce && !stop_mode;
   assign tick = oversample_clock;
   assign sif.tick = tick;
   assign sif.phase = s_q.phase;
   assign sif.line = line;
   assign stop_idx = char_9bit ? rx_pkg::STOP_INDEX_9 : rx_pkg::STOP_INDEX_8;
   assign quiet_len = char_9bit ? rx_pkg::QUIET_ONES_9 : rx_pkg::QUIET_ONES_8;
   assign st_ones = 3'(s_q.start_smp[0]) + 3'(s_q.start_smp[1]) + 3'(s_q.start_smp[2]);
   // Debug break blocks clearing unless software explicitly allows it.
   assign clear_ok = !debug_break || debug_clear_allow;
   // Assemble the received word; for 8-bit frames bit 8 copies bit 7.
   always_comb
   begin
      data_word = s_q.shift;
      if (!char_9bit)
      begin
         data_word = {s_q.shift[8], s_q.shift[8:1]};
      end
      par_bad = parity_enable && ((^(char_9bit ? s_q.shift : {1'b0, s_q.shift[8:1]}))
         != parity_odd);
   end
   // Main next-state process: frame sequencing, flag set/clear, interrupts.
   always_comb
   begin
      s_d = s_q;
      if (standby_set)
      begin
         s_d.standby = 1'b1;
      end
      // Two-step clear: arm on status read with any flag set, fire on data access.
      if (status_read && clear_ok && (s_q.full | s_q.quiet | s_q.ovr | s_q.nf | s_q.fe | s_q.pf))
      begin
         s_d.armed = 1'b1;
      end
      if (data_access && s_q.armed && clear_ok)
      begin
         s_d.armed = 1'b0;
         s_d.full = 1'b0;
         s_d.quiet = 1'b0;
         s_d.ovr = 1'b0;
         s_d.nf = 1'b0;
         s_d.fe = 1'b0;
         s_d.pf = 1'b0;
      end
      if (tick)
      begin
         s_d.phase = s_q.phase + 4'h1;
         s_d.ticks = s_q.ticks + 8'h01;
         s_d.hist = {s_q.hist[1:0], line};
         case (s_q.st)
            rx_pkg::idle_st:
            begin
               s_d.phase = 4'h0;
               // Idle counting of ones; each bit time is sixteen ticks.
               if (line && s_q.quiet_armed)
               begin
                  s_d.ticks = s_q.ticks + 8'h01;
                  if (s_q.ticks == 8'hff)
                  begin
                     s_d.ticks = 8'hff;
                  end
                  if (s_q.ticks[3:0] == rx_pkg::PH_LAST)
                  begin
                     s_d.ones = s_q.ones + 4'h1;
                     if (s_q.ones + 4'h1 >= quiet_len)
                     begin
                        s_d.quiet_armed = 1'b0;
                        if (s_q.standby && !address_wake)
                        begin
                           s_d.standby = 1'b0;
                        end
                        else if (!s_q.standby)
                        begin
                           s_d.quiet = 1'b1;
                        end
                     end
                  end
               end
               // A fall after three ones is a possible start bit.
               if (s_q.hist == 3'h7 && !line)
               begin
                  s_d.st = rx_pkg::start_st;
                  s_d.phase = 4'h1;
                  s_d.ticks = 8'h01;
                  s_d.char_noise = 1'b0;
                  s_d.start_smp = 3'h0;
                  s_d.ones = quiet_count_start_select ? 4'h0 : 4'h1;
                  s_d.quiet_armed = !quiet_count_start_select;
               end
            end
            rx_pkg::start_st:
            begin
               if (s_q.phase == rx_pkg::PH_START_A || s_q.phase == rx_pkg::PH_START_B
                  || s_q.phase == rx_pkg::PH_START_C)
               begin
                  s_d.start_smp = {s_q.start_smp[1:0], line};
               end
               if (s_q.phase == rx_pkg::PH_BIT_A)
               begin
                  if (st_ones > 3'h1)
                  begin
                     s_d.st = rx_pkg::idle_st;
                     s_d.quiet_armed = 1'b0;
                  end
                  else
                  begin
                     s_d.char_noise = (st_ones == 3'h1);
                  end
               end
               if (s_q.phase == rx_pkg::PH_BIT_C)
               begin
                  s_d.char_noise = s_q.char_noise | sif.noisy;
                  s_d.prev_bit = 1'b0;
               end
               if (s_q.phase == rx_pkg::PH_LAST)
               begin
                  s_d.st = rx_pkg::data_st;
                  s_d.bit_idx = 4'h1;
               end
            end
            rx_pkg::data_st:
            begin
               // A fall after a voted 1, away from the vote samples, realigns the count.
               // Early falls (fast sender) and late falls (slow sender) are both caught.
               if (s_q.hist[0] && !line && s_q.prev_bit
                  && (s_q.phase < rx_pkg::PH_BIT_A || s_q.phase > rx_pkg::PH_BIT_C))
               begin
                  s_d.phase = 4'h1;
               end
               if (s_q.phase == rx_pkg::PH_BIT_C)
               begin
                  s_d.prev_bit = sif.vote;
                  s_d.char_noise = s_q.char_noise | sif.noisy;
                  if (s_q.quiet_armed)
                  begin
                     s_d.ones = sif.vote ? s_q.ones + 4'h1 : 4'h0;
                  end
                  if (s_q.bit_idx != stop_idx)
                  begin
                     s_d.shift = {sif.vote, s_q.shift[8:1]};
                  end
                  else
                  begin
                     // Stop bit reached at 154 or 170 ticks after the start edge.
                     s_d.st = rx_pkg::idle_st;
                     s_d.quiet_armed = 1'b1;
                     if (quiet_count_start_select || !sif.vote)
                     begin
                        s_d.ones = 4'h0;
                     end
                     s_d.ticks = 8'h00;
                     if (s_q.standby && !(address_wake && data_word[8]))
                     begin
                        s_d.buf_q = s_q.buf_q;
                     end
                     else if (s_q.full)
                     begin
                        s_d.ovr = 1'b1;
                     end
                     else
                     begin
                        if (s_q.standby)
                        begin
                           s_d.standby = 1'b0;
                        end
                        s_d.full = 1'b1;
                        s_d.buf_q = data_word;
                        s_d.fe = !sif.vote;
                        s_d.nf = s_q.char_noise | sif.noisy;
                        s_d.pf = par_bad;
                     end
                  end
                  s_d.bit_idx = s_q.bit_idx + 4'h1;
               end
            end
            default:
            begin
               s_d.st = rx_pkg::idle_st;
            end
         endcase
      end
      // Requests are registered; standby forces both low.
      s_d.rx_irq = !s_d.standby && ((s_d.full && rx_full_irq_enable)
         || (s_d.quiet && quiet_irq_enable));
      s_d.err_irq = !s_d.standby && ((s_d.ovr && overrun_irq_enable)
         || (s_d.nf && noise_irq_enable) || (s_d.fe && framing_irq_enable)
         || (s_d.pf && parity_irq_enable));
   end
   // Stop mode returns the frame state to idle, discarding any half-received character.
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         s_q <= '0;
         s_q.hist <= 3'h7;
      end
      else if (ce && stop_mode)
      begin
         s_q.st <= rx_pkg::idle_st;
      end
      else if (run)
      begin
         s_q <= s_d;
      end
   end
   assign rx_data_buffer = s_q.buf_q;
   assign receiver_standby = s_q.standby;
   assign rx_full_flag = s_q.full;
   assign quiet_flag = s_q.quiet;
   assign overrun_flag = s_q.ovr;
   assign noise_flag = s_q.nf;
   assign framing_fault_flag = s_q.fe;
   assign parity_fault_flag = s_q.pf;
   assign rx_irq = s_q.rx_irq;
   assign err_irq = s_q.err_irq;

   property p_fe_with_full;
      @(posedge clk_sys) disable iff (rst)
      $rose(s_q.fe) |-> $rose(s_q.full);
   endproperty
   a_fe_with_full: assert property (p_fe_with_full) else $error("fault without full");
   property p_standby_quiet;
      @(posedge clk_sys) disable iff (rst)
      s_q.standby |-> !s_q.rx_irq && !s_q.err_irq;
   endproperty
   a_standby_quiet: assert property (p_standby_quiet) else $error("irq in standby");
   property p_ovr_keeps;
      @(posedge clk_sys) disable iff (rst)
      $rose(s_q.ovr) |-> $stable(s_q.buf_q);
   endproperty
   a_ovr_keeps: assert property (p_ovr_keeps) else $error("overrun changed buffer");
   property p_rx_irq;
      @(posedge clk_sys) disable iff (rst)
      (run && s_q.full && rx_full_irq_enable && !s_q.standby && !standby_set
         && !data_access) |=> s_q.rx_irq;
   endproperty
   a_rx_irq: assert property (p_rx_irq) else $error("no receive irq");
   property p_err_irq;
      @(posedge clk_sys) disable iff (rst)
      s_q.err_irq |-> (s_q.fe || s_q.nf || s_q.pf || s_q.ovr);
   endproperty
   a_err_irq: assert property (p_err_irq) else $error("stray error irq");
   property p_stop_hold;
      @(posedge clk_sys) disable iff (rst)
      stop_mode |=> $stable(s_q.full) && $stable(s_q.buf_q);
   endproperty
   a_stop_hold: assert property (p_stop_hold) else $error("stop changed state");
   property p_break_protect;
      @(posedge clk_sys) disable iff (rst)
      (debug_break && !debug_clear_allow && s_q.full) |=> s_q.full;
   endproperty
   a_break_protect: assert property (p_break_protect) else $error("break cleared");
   property p_idle_wake;
      @(posedge clk_sys) disable iff (rst)
      $fell(s_q.standby) && !address_wake |-> !$rose(s_q.quiet);
   endproperty
   a_idle_wake: assert property (p_idle_wake) else $error("quiet on wake");
   c_full: cover property (@(posedge clk_sys) $rose(s_q.full));
   c_fe: cover property (@(posedge clk_sys) $rose(s_q.fe));
   c_wake: cover property (@(posedge clk_sys) $fell(s_q.standby));
endmodule : rx_status

// *** dv/serial_tx_model.sv ***
/*
 Far-end serial transmitter model that drives the receive line of rx_status.
 Assumes clk_sys is the bench clock and that bit times are given in its cycles.
*/
`timescale 1ns/1ps
module serial_tx_model
(
   input wire logic clk_sys,
   output logic line
);
   // The line rests at mark, so the receiver never sees a false start between frames.
   initial line = 1'b1;
   // Sends a start bit, nb data bits LSB first, then the stop level sb.
   // Bit gb is inverted for one tick near its middle, which spoils a single vote sample.
   task automatic send_char(input logic [8:0] d, input int nb, input logic sb, input int bc,
      input int gb);
      logic v;
      for (int i = 0; i <= nb + 1; i++)
      begin
         v = (i == 0) ? 1'b0 : (i > nb) ? sb : d[i-1];
         for (int c = 0; c < bc; c++)
         begin
            @(negedge clk_sys);
            line = (i == gb && c >= 35 && c < 39) ? !v : v;
         end
      end
      @(negedge clk_sys);
      line = 1'b1;
   endtask : send_char
endmodule : serial_tx_model

// *** dv/tb_top.sv ***
/*
 Self-checking bench for rx_status: a transmitter model feeds the line, while strobes
 and configuration levels are driven on the falling edge of clk_sys.
 Assumes the design carries its own assertions; ce stays high for the whole run.
*/
`timescale 1ns/1ps
module tb_top;
   localparam int TK = 4;
   localparam int BC = 16 * TK;
   logic clk_sys, rx_pin, oversample_clock = 1'b0, rst = 1'b1, ce = 1'b1, char_9bit = 1'b0;
   logic parity_enable = 1'b0, parity_odd = 1'b0, address_wake = 1'b0, standby_set = 1'b0;
   logic quiet_count_start_select = 1'b0, rx_full_irq_enable = 1'b0, quiet_irq_enable = 1'b0;
   logic overrun_irq_enable = 1'b0, noise_irq_enable = 1'b0, framing_irq_enable = 1'b0;
   logic parity_irq_enable = 1'b0, stop_mode = 1'b0, debug_break = 1'b0, status_read = 1'b0;
   logic debug_clear_allow = 1'b0, data_access = 1'b0;
   logic [8:0] rx_data_buffer;
   logic receiver_standby, rx_full_flag, quiet_flag, overrun_flag, noise_flag;
   logic framing_fault_flag, parity_fault_flag, rx_irq, err_irq, fe_at_full;
   int n_mismatch = 0, checks_done = 0, cyc = 0, lat = 0, tdiv = 0;

   serial_tx_model tx_u (.clk_sys(clk_sys), .line(rx_pin));
   rx_status dut_u (.*);

   initial
   begin
      clk_sys = 1'b0;
      forever #2 clk_sys = !clk_sys;
   end

   // One oversample tick every TK cycles; the run is cut off well past its planned length.
   always @(negedge clk_sys)
   begin
      tdiv <= (tdiv + 1) % TK;
      oversample_clock <= (tdiv == TK - 1);
      cyc <= cyc + 1;
      if (cyc == 40000)
      begin
         n_mismatch++;
         end_sim();
      end
   end

   function automatic logic [8:0] flag_vec();
      return {3'h0, rx_full_flag, quiet_flag, overrun_flag, noise_flag, framing_fault_flag,
         parity_fault_flag};
   endfunction : flag_vec

   task automatic chk(input string what, input logic [8:0] got, input logic [8:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // Status read and buffer access strobes last exactly one cycle each.
   task automatic strobe(input logic r, input logic a);
      @(negedge clk_sys);
      status_read = r;
      data_access = a;
      @(negedge clk_sys);
      status_read = 1'b0;
      data_access = 1'b0;
   endtask : strobe

   task automatic clear();
      strobe(1'b1, 1'b0);
      strobe(1'b0, 1'b1);
   endtask : clear

   task automatic sleep();
      @(negedge clk_sys);
      standby_set = 1'b1;
      @(negedge clk_sys);
      standby_set = 1'b0;
      @(negedge clk_sys);
   endtask : sleep

   task automatic idle(input int bits);
      repeat (bits * BC) @(negedge clk_sys);
   endtask : idle

   // Sends one frame and notes the cycle of the receive-full rise and framing at that time.
   task automatic rx(input logic [8:0] d, input logic sb = 1'b1, input int nb = 8,
      input int bc = BC, input int gb = -1);
      logic pf;
      pf = rx_full_flag;
      lat = -1;
      fork
         tx_u.send_char(d, nb, sb, bc, gb);
      join_none
      for (int n = 0; n < bc * (nb + 2) + 8; n++)
      begin
         @(negedge clk_sys);
         if (lat < 0 && pf === 1'b0 && rx_full_flag === 1'b1)
         begin
            lat = n;
            fe_at_full = framing_fault_flag;
         end
      end
      wait fork;
   endtask : rx

   task end_sim();
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : end_sim

   initial
   begin
      repeat (6) @(negedge clk_sys);
      rst = 1'b0;
      chk("flags_rst", flag_vec(), 9'h000);
      chk("buf_rst", rx_data_buffer, 9'h000);
      // Bits of 18 ticks decode only if each fall inside the frame realigns the phase.
      rx_full_irq_enable = 1'b1;
      rx(9'h055, 1'b1, 8, 18 * TK);
      chk("buf_slow", rx_data_buffer, 9'h055);
      chk("flags_slow", flag_vec(), 9'h020);
      chk("rx_irq", 9'(rx_irq), 9'h001);
      clear();
      chk("flags_clr", flag_vec(), 9'h000);
      framing_irq_enable = 1'b1;
      rx(9'h0c3, 1'b0);
      chk("fe_with_full", 9'(fe_at_full), 9'h001);
      chk("flags_fe", flag_vec(), 9'h022);
      chk("err_irq_fe", 9'(err_irq), 9'h001);
      chk("buf_bit8", rx_data_buffer, 9'h1c3);
      chk("lat8", 9'(lat >= 154 * TK && lat <= 154 * TK + 8), 9'h001);
      clear();
      rx(9'h000, 1'b0);
      chk("flags_break", flag_vec(), 9'h022);
      clear();
      noise_irq_enable = 1'b1;
      rx(9'h0a5, 1'b1, 8, BC, 9);
      chk("flags_stop_noise", flag_vec(), 9'h024);
      chk("err_irq_nf", 9'(err_irq), 9'h001);
      clear();
      rx(9'h03c, 1'b1, 8, BC, 3);
      chk("buf_noisy", rx_data_buffer, 9'h03c);
      chk("flags_data_noise", flag_vec(), 9'h024);
      clear();
      char_9bit = 1'b1;
      rx(9'h1a5, 1'b1, 9);
      chk("buf_9bit", rx_data_buffer, 9'h1a5);
      chk("lat9", 9'(lat >= 170 * TK && lat <= 170 * TK + 8), 9'h001);
      clear();
      char_9bit = 1'b0;
      parity_enable = 1'b1;
      parity_irq_enable = 1'b1;
      rx(9'h001);
      chk("flags_even", flag_vec(), 9'h021);
      chk("err_irq_pe", 9'(err_irq), 9'h001);
      clear();
      parity_odd = 1'b1;
      rx(9'h001);
      chk("flags_odd", flag_vec(), 9'h020);
      clear();
      parity_enable = 1'b0;
      overrun_irq_enable = 1'b1;
      rx(9'h011);
      rx(9'h022);
      chk("buf_overrun", rx_data_buffer, 9'h011);
      chk("flags_overrun", flag_vec(), 9'h028);
      chk("err_irq_or", 9'(err_irq), 9'h001);
      clear();
      quiet_irq_enable = 1'b1;
      quiet_count_start_select = 1'b1;
      rx_full_irq_enable = 1'b0;
      rx(9'h0ff);
      idle(3);
      chk("quiet_from_stop", flag_vec(), 9'h020);
      chk("rx_irq_gated", 9'(rx_irq), 9'h000);
      idle(9);
      chk("quiet_set", flag_vec(), 9'h030);
      chk("rx_irq_quiet", 9'(rx_irq), 9'h001);
      clear();
      rx_full_irq_enable = 1'b1;
      quiet_count_start_select = 1'b0;
      rx(9'h0ff);
      idle(3);
      chk("quiet_from_start", flag_vec(), 9'h030);
      clear();
      quiet_count_start_select = 1'b1;
      address_wake = 1'b1;
      rx(9'h012);
      sleep();
      chk("standby_on", 9'(receiver_standby), 9'h001);
      chk("rx_irq_standby", 9'(rx_irq), 9'h000);
      clear();
      rx(9'h012);
      chk("flags_asleep", flag_vec(), 9'h000);
      rx(9'h092);
      chk("standby_mark", 9'(receiver_standby), 9'h000);
      chk("flags_mark", flag_vec(), 9'h020);
      clear();
      address_wake = 1'b0;
      // Standby is set right after traffic, so an idle line cannot wake it at once.
      sleep();
      rx(9'h012);
      chk("standby_busy", 9'(receiver_standby), 9'h001);
      idle(12);
      chk("standby_idle", 9'(receiver_standby), 9'h000);
      chk("flags_idle_wake", flag_vec(), 9'h000);
      rx(9'h055);
      debug_break = 1'b1;
      clear();
      chk("flags_guarded", flag_vec(), 9'h020);
      debug_clear_allow = 1'b1;
      clear();
      debug_break = 1'b0;
      chk("flags_dbg_clr", flag_vec(), 9'h000);
      rx(9'h055);
      strobe(1'b1, 1'b0);
      debug_break = 1'b1;
      debug_clear_allow = 1'b0;
      strobe(1'b0, 1'b1);
      chk("flags_armed_break", flag_vec(), 9'h020);
      debug_break = 1'b0;
      strobe(1'b0, 1'b1);
      chk("flags_armed_after", flag_vec(), 9'h000);
      rx(9'h066);
      stop_mode = 1'b1;
      clear();
      chk("flags_stop", flag_vec(), 9'h020);
      chk("buf_stop", rx_data_buffer, 9'h066);
      stop_mode = 1'b0;
      clear();
      chk("flags_resume", flag_vec(), 9'h000);
      end_sim();
   end
endmodule : tb_top
